// ==== design/spc_map.vh ====
/*
 * Register offsets, field positions, reset values and timing counts of the
 * serial port control block.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef SPC_MAP_VH
`define SPC_MAP_VH

// Register byte addresses on the APB
`define SPC_CTRL_ADDR        12'h000
`define SPC_TXDATA_ADDR      12'h004
`define SPC_RXDATA_ADDR      12'h008
`define SPC_STATUS_ADDR      12'h00c

// Control register fields
`define SPC_CLK_PIN_DIS      12
`define SPC_DOUT_PIN_DIS     11
`define SPC_WORD16           10
`define SPC_SAMPLE_END       9
`define SPC_EDGE_SEL         8
`define SPC_SEL_EN           7
`define SPC_POLARITY         6
`define SPC_MASTER_EN        5
`define SPC_SECONDARY_PRESCALE_HI          4
`define SPC_SECONDARY_PRESCALE_LO          2
`define SPC_PRIMARY_PRESCALE_HI          1
`define SPC_PRIMARY_PRESCALE_LO          0
`define SPC_FRAMED_EN        13
`define SPC_CTRL_RESET       16'h0000
`define SPC_CTRL_WMASK       16'h1fff

// Timing: system clock period and bench link clock period
`define SPC_CLK_PERIOD_NS    40
`define SPC_LINK_PERIOD_NS   320

`endif

// ==== design/spc_fifo.v ====
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
module spc_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             ref_clk,
    input  wire             rst_n,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output reg              outValid,
    input  wire             outReady,
    output reg  [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_q;
    reg [AW-1:0]    rdPtr_q;
    reg [AW:0]      count_q;
    wire            doWrite;
    wire            doRead;

    assign inReady = (count_q != DEPTH[AW:0]);
    assign doWrite = inValid && inReady;
    assign doRead  = (count_q != {(AW+1){1'b0}}) && (!outValid || outReady);

    // Storage write
    always @(posedge ref_clk) begin
        if (doWrite) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers, fill level and registered read port
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q  <= {AW{1'b0}};
            rdPtr_q  <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
            outValid <= 1'b0;
            outData  <= {WIDTH{1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (doRead) begin
                rdPtr_q  <= rdPtr_q + 1'b1;
                outData  <= mem[rdPtr_q];
                outValid <= 1'b1;
            end else if (outReady) begin
                outValid <= 1'b0;
            end
            count_q <= count_q + {{AW{1'b0}}, doWrite} - {{AW{1'b0}}, doRead};
        end
    end
endmodule

// ==== design/spc_port.v ====
/*
 * Serial peripheral port: control register, clock generation, shift engine
 * and pin muxing, reached over APB.
 * Assumes link pins arrive asynchronously and are synchronised here.
 */
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
// Overview of operation
// - master with clock-pin disable set stops driving clock; pin becomes general I/O.
// - data-out pin disable set releases data-out pin to general I/O.
// - word size bit set means 16-bit words, clear means 8-bit.
// - master samples at end of output time when set, middle when clear.
// - edge bit set changes data active-to-idle, clear idle-to-active.
// - polarity bit set idles clock high, clear idles low.
// - slave with select enable uses select pin, else ignores it.
// - master enable bit set gives master role, clear slave role.
// - framed mode ignores edge bit; software programs it zero.
// - top three control bits read zero; control bits reset to zero.
`include "spc_map.vh"
module spc_port #(
    parameter DEPTH = 16
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        sckIn,
    output reg         sckOut,
    output reg         sckOe,
    input  wire        sdiIn,
    output reg         sdoOut,
    output reg         sdoOe,
    input  wire        selIn_n,
    output reg         sckGpio,
    output reg         sdoGpio,
    output reg         selGpio
);
    reg  [15:0] ctrl_q;
    reg  [15:0] rxData_q;
    reg         rxFull_q;
    reg         rxOvf_q;
    reg  [15:0] shift_q;
    reg  [4:0]  bitCnt_q;
    reg         busy_q;
    reg  [8:0]  divCnt_q;
    reg         sclk_q;
    reg  [2:0]  sckSync_q;
    reg  [1:0]  sdiSync_q;
    reg  [1:0]  selSync_q;
    reg         sampled_q;
    wire        txValid;
    wire        txReady;
    wire [15:0] txData;
    wire        fifoInReady;
    wire        apbWr;
    wire        apbRd;
    wire        master;
    wire        word16;
    wire [4:0]  nBits;
    wire [8:0]  halfDiv;
    wire        cpol;
    wire        cpha;
    wire        selActive;
    wire        sEdgeRise;
    wire        sEdgeFall;
    wire        sLead;
    wire        sTrail;
    wire        mTick;
    wire [9:0]  prodFull;
    wire        mLead;
    wire        mChg;
    wire        mTake;
    wire        sChg;
    wire        sTake;
    wire [15:0] rxNext;
    reg  [15:0] rxSh_q;

    // Prescale factor product; primary 64/16/4/1, secondary 8..1
    // Pin synchronisers add a round trip of five clocks, so a master link
    // needs a product of 8 or more to read the far side's data in time
    function [9:0] divFactor;
        input [1:0] pre;
        input [2:0] sec;
        reg   [6:0] p;
        begin
            case (pre)
                2'b00:   p = 7'd64;
                2'b01:   p = 7'd16;
                2'b10:   p = 7'd4;
                default: p = 7'd1;
            endcase
            divFactor = p * (4'd8 - {1'b0, sec});
        end
    endfunction

    // Received word aligned to the low end in byte mode
    function [15:0] rxAlign;
        input [15:0] v;
        input        w16;
        begin
            rxAlign = w16 ? v : {8'h00, v[7:0]};
        end
    endfunction

    assign apbWr     = psel && penable && pwrite;
    assign apbRd     = psel && penable && !pwrite;
    assign master    = ctrl_q[`SPC_MASTER_EN];
    assign word16    = ctrl_q[`SPC_WORD16];
    assign nBits     = word16 ? 5'd16 : 5'd8;
    assign cpol      = ctrl_q[`SPC_POLARITY];
    // Edge bit has no effect in framed operation
    assign cpha      = ctrl_q[`SPC_EDGE_SEL] & ~ctrl_q[`SPC_FRAMED_EN];
    assign prodFull  = divFactor(ctrl_q[`SPC_PRIMARY_PRESCALE_HI:`SPC_PRIMARY_PRESCALE_LO],
                                 ctrl_q[`SPC_SECONDARY_PRESCALE_HI:`SPC_SECONDARY_PRESCALE_LO]);
    assign halfDiv   = prodFull[9:1];
    assign mTick     = master && busy_q && (divCnt_q == 9'h000);
    assign selActive = !ctrl_q[`SPC_SEL_EN] || !selSync_q[1];
    assign sEdgeRise = sckSync_q[1] && !sckSync_q[2];
    assign sEdgeFall = !sckSync_q[1] && sckSync_q[2];
    // Leading edge leaves idle level; trailing edge returns to it
    assign sLead     = cpol ? sEdgeFall : sEdgeRise;
    assign sTrail    = cpol ? sEdgeRise : sEdgeFall;
    // Output changes on leading edges when the edge bit is clear
    assign mLead     = (sclk_q == cpol);
    assign mChg      = mLead ^ cpha;
    assign mTake     = ctrl_q[`SPC_SAMPLE_END] ?
                       ((mChg && sampled_q) || (!mLead && bitCnt_q == 5'd1 && !cpha)) :
                       !mChg;
    assign sChg      = cpha ? sTrail : sLead;
    assign sTake     = cpha ? sLead : sTrail;
    assign rxNext    = {rxSh_q[14:0], sdiSync_q[1]};
    assign txReady   = !busy_q && (master || selActive);

    spc_fifo #(
        .WIDTH (16),
        .DEPTH (DEPTH),
        .AW    (4)
    ) txFifo (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .inValid  (apbWr && pready && paddr == `SPC_TXDATA_ADDR),
        .inReady  (fifoInReady),
        .inData   (pwdata[15:0]),
        .outValid (txValid),
        .outReady (txReady),
        .outData  (txData)
    );

    // Link pin synchronisers
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sckSync_q <= 3'b000;
            sdiSync_q <= 2'b00;
            selSync_q <= 2'b11;
        end else begin
            sckSync_q <= {sckSync_q[1:0], sckIn};
            sdiSync_q <= {sdiSync_q[0], sdiIn};
            selSync_q <= {selSync_q[0], selIn_n};
        end
    end

    // APB slave: one wait-free access, unmapped address flags an error
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q  <= `SPC_CTRL_RESET;
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                case (paddr)
                    `SPC_CTRL_ADDR:   prdata <= {16'h0000, ctrl_q & `SPC_CTRL_WMASK};
                    `SPC_RXDATA_ADDR: prdata <= {16'h0000, rxData_q};
                    `SPC_STATUS_ADDR: prdata <= {28'h0000000, ctrl_q[`SPC_FRAMED_EN],
                                                 rxOvf_q, rxFull_q, busy_q};
                    `SPC_TXDATA_ADDR: prdata <= {31'h00000000, fifoInReady};
                    default: begin
                        prdata  <= 32'h00000000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
            if (apbWr && pready && paddr == `SPC_CTRL_ADDR) begin
                ctrl_q[12:0] <= pwdata[12:0];
            end
            if (apbWr && pready && paddr == `SPC_STATUS_ADDR) begin
                ctrl_q[`SPC_FRAMED_EN] <= pwdata[3];
            end
        end
    end

    // Shift engine: master clock generation and slave edge following
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q   <= 16'h0000;
            bitCnt_q  <= 5'd0;
            busy_q    <= 1'b0;
            divCnt_q  <= 9'h000;
            sclk_q    <= 1'b0;
            sampled_q <= 1'b0;
            rxData_q  <= 16'h0000;
            rxFull_q  <= 1'b0;
            rxOvf_q   <= 1'b0;
            rxSh_q    <= 16'h0000;
        end else begin
            if (apbRd && pready && paddr == `SPC_RXDATA_ADDR) begin
                rxFull_q <= 1'b0;
            end
            if (!busy_q) begin
                sclk_q <= cpol;
                if (txValid && txReady) begin
                    shift_q  <= word16 ? txData : {txData[7:0], 8'h00};
                    bitCnt_q <= nBits;
                    busy_q   <= 1'b1;
                    divCnt_q <= halfDiv;
                    sampled_q <= 1'b0;
                end
            end else if (master) begin
                divCnt_q <= (divCnt_q == 9'h000) ? halfDiv : divCnt_q - 9'h001;
                if (mTick) begin
                    // First edge of a frame never moves the output
                    sclk_q    <= ~sclk_q;
                    sampled_q <= 1'b1;
                    if (mTake) begin
                        rxSh_q <= rxNext;
                    end
                    if (mChg && sampled_q) begin
                        shift_q <= {shift_q[14:0], 1'b0};
                    end
                    if (!mLead) begin
                        bitCnt_q <= bitCnt_q - 5'd1;
                        if (bitCnt_q == 5'd1) begin
                            busy_q   <= 1'b0;
                            rxOvf_q  <= rxOvf_q | rxFull_q;
                            rxFull_q <= 1'b1;
                            rxData_q <= rxAlign(mTake ? rxNext : rxSh_q, word16);
                        end
                    end
                end
            end else if (selActive) begin
                // Slave role samples on the edge opposite the output change
                if (sTake) begin
                    rxSh_q    <= rxNext;
                    sampled_q <= 1'b1;
                    bitCnt_q  <= bitCnt_q - 5'd1;
                    if (bitCnt_q == 5'd1) begin
                        busy_q   <= 1'b0;
                        rxOvf_q  <= rxOvf_q | rxFull_q;
                        rxFull_q <= 1'b1;
                        rxData_q <= rxAlign(rxNext, word16);
                    end
                end
                if (sChg && sampled_q) begin
                    shift_q <= {shift_q[14:0], 1'b0};
                end
            end else begin
                busy_q <= 1'b0;
            end
        end
    end

    // Pin ownership and drivers
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sckOut  <= 1'b0;
            sckOe   <= 1'b0;
            sdoOut  <= 1'b0;
            sdoOe   <= 1'b0;
            sckGpio <= 1'b1;
            sdoGpio <= 1'b1;
            selGpio <= 1'b1;
        end else begin
            sckOut  <= busy_q ? sclk_q : cpol;
            sckOe   <= master && !ctrl_q[`SPC_CLK_PIN_DIS];
            sckGpio <= master && ctrl_q[`SPC_CLK_PIN_DIS];
            sdoOut  <= shift_q[15];
            sdoOe   <= !ctrl_q[`SPC_DOUT_PIN_DIS] && (master || selActive);
            sdoGpio <= ctrl_q[`SPC_DOUT_PIN_DIS];
            selGpio <= master || !ctrl_q[`SPC_SEL_EN];
        end
    end
endmodule

// ==== testbench/spc_chk.sv ====
/* Checker for the serial port: APB answer timing, control readback,
   pin ownership, clock idle level and half period.
   Assumes it is bound to spc_port and sees only that module's ports. */
`include "spc_map.vh"
module spc_chk #(
    parameter int DEPTH = 16
) (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sckOut,
    input wire logic        sckOe,
    input wire logic        sckGpio,
    input wire logic        sdoGpio,
    input wire logic        selGpio
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] ctrlQ;
    logic [1:0]  quietQ;
    logic        wroteQ;
    logic        sckPrevQ;
    int          gapQ;
    wire         rdDone  = pready && psel && penable && !pwrite;
    wire         wrCtrl  = pready && psel && penable && pwrite && paddr == `SPC_CTRL_ADDR;
    wire         ok      = wroteQ && quietQ == 2'h3;
    wire         mst     = ctrlQ[`SPC_MASTER_EN];
    wire         mapped  = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
    wire [9:0]   prod    = (10'h040 >> (2 * ctrlQ[1:0])) * (10'h008 - ctrlQ[4:2]);
    wire [9:0]   halfExp = prod >> 1;
    // Shadow of the control register, settle count and clock gap count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlQ <= 13'h0000;
            quietQ <= 2'h0;
            wroteQ <= 1'b0;
            sckPrevQ <= 1'b0;
            gapQ <= 0;
        end else begin
            ctrlQ <= wrCtrl ? pwdata[12:0] : ctrlQ;
            wroteQ <= wroteQ | wrCtrl;
            quietQ <= wrCtrl ? 2'h0 : (quietQ == 2'h3 ? quietQ : quietQ + 2'h1);
            sckPrevQ <= sckOut;
            gapQ <= (sckOut != sckPrevQ) ? 0 : gapQ + 1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_ready_answer: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    a_ctrl_readback: assert property (
        rdDone && paddr == `SPC_CTRL_ADDR |-> prdata == {19'h0, ctrlQ})
        else $error("control readback wrong");
    a_clk_release: assert property (ok && mst && ctrlQ[12] |-> sckGpio && !sckOe)
        else $error("clock pin not released");
    a_clk_drive: assert property (ok && mst && !ctrlQ[12] |-> !sckGpio && sckOe)
        else $error("clock pin not driven in master role");
    a_slave_listen: assert property (ok && !mst |-> !sckOe)
        else $error("clock driven in slave role");
    a_dout_release: assert property (ok |-> sdoGpio == ctrlQ[11])
        else $error("data out pin ownership wrong");
    a_sel_release: assert property (ok && !mst |-> selGpio == !ctrlQ[7])
        else $error("select pin ownership wrong");
    a_clk_idle: assert property (
        rdDone && paddr == `SPC_STATUS_ADDR && !prdata[0] && ok && mst && !ctrlQ[12]
        |-> sckOut == ctrlQ[6])
        else $error("clock idle level wrong");
    a_half_period: assert property (
        ok && mst && sckOut != sckPrevQ && prod > 10'h001 |-> gapQ >= halfExp - 1)
        else $error("clock half period too short");
    c_master_edge: cover property (ok && mst && sckOut != sckPrevQ);
    c_slave_sel: cover property (ok && !mst && ctrlQ[7]);
    c_err_answer: cover property (pready && pslverr);
endmodule
bind spc_port spc_chk #(.DEPTH(DEPTH)) u_spc_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sckOut(sckOut), .sckOe(sckOe), .sckGpio(sckGpio), .sdoGpio(sdoGpio), .selGpio(selGpio));

// ==== testbench/spc_partner.sv ====
/* Far-side serial device: slave when the port is master, master with its
   own link clock when the port is slave. Resolves the link wires.
   Assumes the bench tells it polarity, edge and width, and gates it by act. */
module spc_partner (
    input wire logic         ref_clk,
    input wire logic         sckOut,
    input wire logic         sckOe,
    input wire logic         sdoOut,
    input wire logic         sdoOe,
    input wire logic         pol,
    input wire logic         edgeSel,
    input wire logic         word16,
    input wire logic         act,
    output logic             sckLine,
    output logic             sdiLine,
    output logic             selLine_n,
    output logic [15:0]      rxWord,
    output int               bitCnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] txWord;
    logic        tog;
    logic        sckPrev;
    logic        sdoLast;
    int          w;
    int          idx;
    // Clock idles at the polarity level outside frames
    assign sckLine = sckOe ? sckOut : (pol ^ tog);
    wire   sdoLine = sdoOe ? sdoOut : ~sdoLast;
    always_comb w = word16 ? 16 : 8;
    initial begin
        tog = 1'b0;
        selLine_n = 1'b1;
        sdiLine = 1'b0;
        rxWord = 16'h0000;
        bitCnt = 0;
        idx = 0;
        sdoLast = 1'b0;
        txWord = 16'h0000;
    end
    // Oversample the link clock; change data on one edge, sample on the other
    always @(posedge ref_clk) begin
        sckPrev <= sckLine;
        if (sdoOe) sdoLast <= sdoOut;
        if (act && sckLine !== sckPrev) begin
            if ((sckLine != pol) ^ edgeSel) begin
                if (idx < w) sdiLine <= txWord[w - 1 - idx];
            end else begin
                rxWord <= {rxWord[14:0], sdoLine};
                bitCnt <= bitCnt + 1;
                idx <= idx + 1;
            end
        end
    end
    task load(input logic [15:0] v);
        txWord = v;
        idx = 0;
        sdiLine <= v[w - 1];
    endtask
    // One selected frame at a 320 ns link period
    task frame();
        selLine_n = 1'b0;
        #647;
        repeat (2 * w) begin
            #160 tog = ~tog;
        end
        #647 selLine_n = 1'b1;
    endtask
endmodule

// ==== testbench/testbench.sv ====
/* Self-checking bench for the serial port: registers over APB, master and
   slave transfers through the far-side model, TX buffer overflow.
   Assumes spc_port, spc_partner and the bound checker are compiled. */
`include "spc_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rst_n, psel, penable, pwrite, pol, edgeSel, word16, act, errQ;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, r;
    logic [15:0] dw, pw, msk;
    logic [1:0]  p;
    logic [2:0]  s;
    wire  [31:0] prdata;
    wire  [15:0] rxWord;
    wire         pready, pslverr, sckOut, sckOe, sdoOut, sdoOe, sckGpio, sdoGpio, selGpio;
    wire         sckLine, sdiLine, selLine_n;
    int          pBits, fails, comparisons, base, n;
    spc_port #(.DEPTH(16)) u_spc_port (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sckIn(sckLine), .sckOut(sckOut), .sckOe(sckOe), .sdiIn(sdiLine), .sdoOut(sdoOut),
        .sdoOe(sdoOe), .selIn_n(selLine_n), .sckGpio(sckGpio), .sdoGpio(sdoGpio),
        .selGpio(selGpio));
    spc_partner u_spc_partner (
        .ref_clk(ref_clk), .sckOut(sckOut), .sckOe(sckOe), .sdoOut(sdoOut), .sdoOe(sdoOe),
        .pol(pol), .edgeSel(edgeSel), .word16(word16), .act(act), .sckLine(sckLine),
        .sdiLine(sdiLine), .selLine_n(selLine_n), .rxWord(rxWord), .bitCnt(pBits));
    // System clock, 40 ns period
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    function logic [31:0] ctrlRead(input logic [15:0] v);
        return {16'h0000, v & `SPC_CTRL_WMASK};
    endfunction
    task chk(input string what, input logic [31:0] e, input logic [31:0] v);
        comparisons++;
        if (v !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, e, v);
        end
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        logic got;
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        // Answer is looked at where settled, then the edge that takes it passes
        do begin
            @(negedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        got = pready;
        rd = prdata;
        errQ = pslverr;
        @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        chk("apb answer", 1, got);
    endtask
    task setCtrl(input logic [15:0] v);
        act <= 1'b0;
        pol <= v[6]; edgeSel <= v[8]; word16 <= v[10];
        apb(1'b1, `SPC_CTRL_ADDR, {16'h0000, v});
        apb(1'b0, `SPC_CTRL_ADDR, 32'h0);
        chk("ctrl readback", ctrlRead(v), rd);
    endtask
    task waitIdle(input int target);
        n = 0;
        while (pBits < target && n < 9000) begin
            @(posedge ref_clk);
            n++;
        end
        n = 0;
        do begin
            apb(1'b0, `SPC_STATUS_ADDR, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 200);
    endtask
    task xfer(input logic slave);
        msk = word16 ? 16'hffff : 16'h00ff;
        dw = $urandom;
        pw = $urandom;
        u_spc_partner.load(pw);
        base = pBits;
        @(posedge ref_clk) act <= 1'b1;
        apb(1'b1, `SPC_TXDATA_ADDR, {16'h0000, dw});
        if (slave) u_spc_partner.frame();
        waitIdle(base + (word16 ? 16 : 8));
        apb(1'b0, `SPC_RXDATA_ADDR, 32'h0);
        chk("rx word", pw & msk, rd[15:0]);
        chk("link word", dw & msk, rxWord & msk);
        chk("bit count", word16 ? 16 : 8, pBits - base);
    endtask
    task summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog: ends a hung run
    initial begin
        #2000000;
        fails++;
        summarize();
    end
    // Main sequence
    initial begin
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        pol = 1'b0; edgeSel = 1'b0; word16 = 1'b0; act = 1'b0; rst_n = 1'b0;
        fails = 0;
        comparisons = 0;
        n = $urandom(32'h0a340b55);
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1'b0, `SPC_CTRL_ADDR, 32'h0);
        chk("ctrl reset", `SPC_CTRL_RESET, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped error", 1, errQ);
        setCtrl(16'hfffe);
        for (int i = 0; i < 8; i++) begin
            setCtrl({3'h0, i[0], i[1], 3'h0, i[0], 1'b0, i[2], 5'h01});
            chk("data pin gpio", i[1], sdoGpio);
            if (i[2]) chk("clock pin gpio", i[0], sckGpio);
            else chk("select pin gpio", !i[0], selGpio);
        end
        $display("test registers and pins done");
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            p = 2'h1 + {1'b0, r[8]};
            s = r[6:4];
            if (i == 0) begin p = 2'h3; s = 3'h0; end
            if (i == 1) begin p = 2'h1; s = 3'h0; end
            if (p == 2'h2 && s == 3'h7) s = 3'h6; // Link round trip needs product of 8 or more
            if (p == 2'h3 && s == 3'h7) s = 3'h6;
            setCtrl({5'h00, r[2:0], 1'b0, r[3], 1'b1, s, p});
            xfer(1'b0);
        end
        $display("test master transfers done");
        setCtrl(16'h0022);
        base = pBits;
        u_spc_partner.load(16'h0000);
        @(posedge ref_clk) act <= 1'b1;
        // 16 stored, one in the read register, one shifting; the last two drop
        for (int k = 0; k < 20; k++) apb(1'b1, `SPC_TXDATA_ADDR, 32'h30 + k);
        waitIdle(base + 144);
        chk("buffered bits", 144, pBits - base);
        chk("last byte", 32'h41, rxWord[7:0]);
        $display("test buffer overflow done");
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            setCtrl({5'h00, r[2], 1'b0, r[1], 1'b1, r[0], 6'h00});
            xfer(1'b1);
        end
        $display("test slave transfers done");
        summarize();
    end
endmodule
